// ### bkpc_comparator.v
// Bus breakpoint comparator with control and compare registers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - Mode field decodes off, SOFTWARE_INTERRUPT dual, debug full, debug dual.
// RULE2 - No match is signalled while background debug mode is active.
// RULE3 - SOFTWARE_INTERRUPT dual mode raises software interrupt; program fetch tagging only.
// RULE4 - SOFTWARE_INTERRUPT dual mode ignores direction enables, values and byte masks.
// RULE5 - In dual modes, data compare enable enables the second breakpoint.
// RULE6 - Full mode ignores second low-byte enable and second direction bits.
// RULE7 - Full mode data enable and masks qualify unless program-address set.
// RULE8 - Debug dual ignores masks; program-address set also drops direction.
// RULE9 - Debug entry only when the debug unit reports debug enabled.
// RULE10 - Software selects debug modes only with debug enabled; unenforced.
// RULE11 - Program-address 0 breaks at boundary; 1 tags executed opcodes only.
// RULE12 - First low-byte enable picks upper-byte or full address compare.
// RULE13 - Second low-byte enable picks upper-byte or full compare, dual only.
// RULE14 - Data compare enable 0 drops data registers from every compare.
// RULE15 - High mask 0 compares data 15:8; 1 drops that byte.
// RULE16 - Low mask 0 compares data 7:0; 1 drops that byte.
// RULE17 - First direction enable set: value 0 matches writes, 1 reads.
// RULE18 - Second direction enable with data enable: 0 writes, 1 reads.
// RULE19 - Control registers read and write anytime, reset to zero.
// RULE20 - Tag travels with instruction; debug entry when it reaches head.
// RULE21 - Compare registers cleared only by power-on reset.
// RULE22 - Each enabled comparator checked every bus cycle, all qualifiers.
`include "bkpc_defines.vh"

module bkpc_comparator
(
   // Clock and resets
   input wire clk,
   input wire rst,
   input wire por,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // CPU bus
   input wire bus_valid,
   input wire [15:0] bus_addr,
   input wire [15:0] bus_data,
   input wire bus_read,
   input wire bus_fetch,
   input wire queue_advance,
   input wire head_execute,
   // Debug unit
   input wire debug_active,
   input wire debug_enabled,
   // Break requests
   output reg swi_request,
   output reg debug_request,
   output wire [2:0] queue_tags,
   output wire [1:0] match_status
);

   parameter QUEUE_DEPTH = 3;

   // Two breakpoints; the second borrows the data compare pair
   localparam NUM_BP = 2;
   localparam NUM_CMP = 4;

   // Control and compare storage
   reg [7:0] ctrl0_reg;
   reg [7:0] ctrl0_next;
   reg [7:0] ctrl1_reg;
   reg [7:0] ctrl1_next;
   // Index 0 address high, 1 address low, 2 data high, 3 data low
   reg [7:0] cmp_reg [0:NUM_CMP-1];
   reg [7:0] rdata_next;
   integer i;

   // Tag queue, pending data break and match status
   reg [QUEUE_DEPTH-1:0] tag_reg;
   wire [QUEUE_DEPTH-1:0] tag_next;
   reg pending_reg;
   reg pending_next;
   reg [1:0] status_reg;
   reg [1:0] status_next;
   reg swi_next;
   reg debug_next;

   // Register port decode
   wire [7:0] cmp_offset;
   wire cmp_sel;
   wire [1:0] cmp_index;
   wire ctrl0_sel;
   wire ctrl1_sel;

   // Control fields
   wire mode_select_hi;
   wire mode_select_lo;
   wire break_on_program_address;
   wire second_low_byte_enable;
   wire first_low_byte_enable;
   wire data_compare_enable;
   wire high_data_mask;
   wire low_data_mask;
   wire second_dir_compare_enable;
   wire second_dir_value;
   wire first_dir_compare_enable;
   wire first_dir_value;
   wire [NUM_BP-1:0] low_byte_enable;
   wire [NUM_BP-1:0] dir_compare_enable;
   wire [NUM_BP-1:0] dir_value;

   // Compare bytes
   wire [7:0] addr_compare_high;
   wire [7:0] addr_compare_low;
   wire [7:0] data_compare_high;
   wire [7:0] data_compare_low;

   // Mode decode
   wire [1:0] mode;
   wire mode_on;
   wire swi_dual;
   wire full;
   wire bdm_dual;
   wire bdm_mode;
   wire dual;
   wire prog_mode;
   wire high_data_ok;
   wire low_data_ok;
   wire data_ok;

   // Match and break paths
   wire [NUM_BP-1:0] bp_hit;
   wire [NUM_BP-1:0] bp_live;
   wire any_hit;
   wire fetch_tag;
   wire data_break;
   wire head_tagged;
   wire head_live;

   genvar bp;
   genvar slot;

   assign ctrl0_sel = (reg_addr == `BKPC_OFS_CTRL0);
   assign ctrl1_sel = (reg_addr == `BKPC_OFS_CTRL1);
   assign cmp_offset = reg_addr - `BKPC_OFS_ADDR_HI;
   assign cmp_sel = (cmp_offset[7:2] == 6'h00);
   assign cmp_index = cmp_offset[1:0];

   // Field breakout of the control registers
   assign mode_select_hi = ctrl0_reg[`BKPC_MODE_HI];
   assign mode_select_lo = ctrl0_reg[`BKPC_MODE_LO];
   assign break_on_program_address = ctrl0_reg[`BKPC_PROG_ADDR];
   assign second_low_byte_enable = ctrl0_reg[`BKPC_SECOND_ALE];
   assign first_low_byte_enable = ctrl0_reg[`BKPC_FIRST_ALE];
   assign data_compare_enable = ctrl1_reg[`BKPC_DATA_EN];
   assign high_data_mask = ctrl1_reg[`BKPC_HIGH_MASK];
   assign low_data_mask = ctrl1_reg[`BKPC_LOW_MASK];
   assign second_dir_compare_enable = ctrl1_reg[`BKPC_SECOND_RWE];
   assign second_dir_value = ctrl1_reg[`BKPC_SECOND_RW];
   assign first_dir_compare_enable = ctrl1_reg[`BKPC_FIRST_RWE];
   assign first_dir_value = ctrl1_reg[`BKPC_FIRST_RW];
   assign low_byte_enable = {second_low_byte_enable, first_low_byte_enable};
   assign dir_compare_enable = {second_dir_compare_enable,
      first_dir_compare_enable};
   assign dir_value = {second_dir_value, first_dir_value};
   assign addr_compare_high = cmp_reg[0];
   assign addr_compare_low = cmp_reg[1];
   assign data_compare_high = cmp_reg[2];
   assign data_compare_low = cmp_reg[3];

   assign mode = {mode_select_hi, mode_select_lo}; // RULE1
   assign mode_on = (mode != `BKPC_MODE_OFF); // RULE1
   assign swi_dual = (mode == `BKPC_MODE_SWI_DUAL); // RULE1
   assign full = (mode == `BKPC_MODE_BDM_FULL); // RULE1
   assign bdm_dual = (mode == `BKPC_MODE_BDM_DUAL); // RULE1
   assign bdm_mode = full | bdm_dual; // RULE1
   assign dual = swi_dual | bdm_dual; // RULE1
   // SOFTWARE_INTERRUPT mode always works through program tagging
   assign prog_mode = break_on_program_address | swi_dual; // RULE3

   // Full-mode data compare; masks only matter in full mode
   assign high_data_ok = high_data_mask |
      (bus_data[15:8] == data_compare_high); // RULE15
   assign low_data_ok = low_data_mask |
      (bus_data[7:0] == data_compare_low); // RULE16
   assign data_ok = prog_mode | ~data_compare_enable |
      (high_data_ok & low_data_ok); // RULE7 RULE14

   // One comparator per breakpoint
   generate
      for (bp = 0; bp < NUM_BP; bp = bp + 1)
      begin : g_bp
         wire [7:0] hi_byte;
         wire [7:0] lo_byte;
         wire hi_ok;
         wire lo_ok;
         wire dir_ok;
         wire enabled;

         if (bp == 0)
         begin : g_first
            assign hi_byte = addr_compare_high;
            assign lo_byte = addr_compare_low;
            assign enabled = mode_on & (dual | data_ok); // RULE6 RULE7
         end
         else
         begin : g_second
            assign hi_byte = data_compare_high;
            assign lo_byte = data_compare_low;
            assign enabled = dual & data_compare_enable; // RULE5 RULE14
         end
         assign hi_ok = (bus_addr[15:8] == hi_byte);
         // Clear low enable widens the match to a 256-byte page
         assign lo_ok = ~low_byte_enable[bp] |
            (bus_addr[7:0] == lo_byte); // RULE12 RULE13
         // Direction is dropped in SOFTWARE_INTERRUPT mode and for program breaks
         assign dir_ok = prog_mode | ~dir_compare_enable[bp] |
            (bus_read == dir_value[bp]); // RULE4 RULE8 RULE17 RULE18
         assign bp_hit[bp] = bus_valid & enabled & hi_ok & lo_ok &
            dir_ok; // RULE22
         // Matches inside the debug firmware would re-trigger forever
         assign bp_live[bp] = bp_hit[bp] & ~debug_active; // RULE2
      end
   endgenerate

   assign any_hit = |bp_live; // RULE2
   // Program breaks only tag opcode fetches
   assign fetch_tag = any_hit & prog_mode & bus_fetch; // RULE11 RULE3
   assign data_break = any_hit & ~prog_mode; // RULE11
   assign head_tagged = tag_reg[QUEUE_DEPTH-1]; // RULE20
   assign head_live = head_execute & ~debug_active; // RULE2

   assign queue_tags = tag_reg;
   assign match_status = status_reg;

   // Tag queue: slot 0 takes the newest fetch, the top slot is the head
   generate
      for (slot = 0; slot < QUEUE_DEPTH; slot = slot + 1)
      begin : g_slot
         wire shift_in;
         wire hold;
         if (slot == 0)
         begin : g_tail
            assign shift_in = fetch_tag;
            assign hold = tag_reg[0] | fetch_tag;
         end
         else
         begin : g_body
            assign shift_in = tag_reg[slot-1];
            assign hold = tag_reg[slot];
         end
         // Entering debug mode drops every tag
         assign tag_next[slot] = debug_active ? 1'b0 :
            (queue_advance ? shift_in : hold); // RULE2 RULE20
      end
   endgenerate

   always @*
   begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      if (reg_wr && ctrl0_sel)
         ctrl0_next = reg_wdata & `BKPC_CTRL0_MASK; // RULE19
      if (reg_wr && ctrl1_sel)
         ctrl1_next = reg_wdata & `BKPC_CTRL1_MASK; // RULE19
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always @*
   begin
      rdata_next = 8'h00;
      if (reg_rd)
      begin
         if (ctrl0_sel)
            rdata_next = ctrl0_reg; // RULE19
         else if (ctrl1_sel)
            rdata_next = ctrl1_reg; // RULE19
         else if (cmp_sel)
            rdata_next = cmp_reg[cmp_index];
      end
   end

   // Data breaks wait for the next instruction boundary
   always @*
   begin
      pending_next = pending_reg;
      if (debug_active)
         pending_next = 1'b0; // RULE2
      else if (data_break)
         pending_next = 1'b1; // RULE11
      else if (head_execute)
         pending_next = 1'b0;
   end

   always @*
   begin
      // Tagged head replaces the opcode with the break
      swi_next = head_live & head_tagged & swi_dual; // RULE3 RULE20
      // Only the enable input gates debug entry; software must check
      debug_next = head_live & bdm_mode & debug_enabled &
         (head_tagged | pending_reg); // RULE9 RULE10 RULE11 RULE20
      status_next = bp_live; // RULE22
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         ctrl0_reg <= `BKPC_CTRL_RESET; // RULE19
         ctrl1_reg <= `BKPC_CTRL_RESET; // RULE19
         reg_rdata <= 8'h00;
         tag_reg <= {QUEUE_DEPTH{1'b0}};
         pending_reg <= 1'b0;
         swi_request <= 1'b0;
         debug_request <= 1'b0;
         status_reg <= 2'h0;
      end
      else
      begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         reg_rdata <= rdata_next;
         tag_reg <= tag_next;
         pending_reg <= pending_next;
         swi_request <= swi_next;
         debug_request <= debug_next;
         status_reg <= status_next;
      end
   end

   // Compare registers survive ordinary resets
   always @(posedge clk)
   begin
      if (por)
      begin
         for (i = 0; i < NUM_CMP; i = i + 1)
            cmp_reg[i] <= `BKPC_CMP_RESET; // RULE21
      end
      else if (reg_wr && cmp_sel)
         cmp_reg[cmp_index] <= reg_wdata;
   end

endmodule

// ### bkpc_comparator_chk.sv
// Port assertions for the breakpoint comparator
`timescale 1ns/1ns
module bkpc_comparator_chk
#(parameter QUEUE_DEPTH = 3)
(
   // Clock and resets
   input wire clk,
   input wire rst,
   input wire por,
   // Register port and break side
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire head_execute,
   input wire debug_active,
   input wire debug_enabled,
   input wire swi_request,
   input wire debug_request,
   input wire [1:0] match_status
);
   logic [1:0] mode_reg;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst || por);
   // Shadow of the mode field, cleared with the control registers
   always @(posedge clk)
      if (rst || por)
         mode_reg <= 2'h0;
      else if (reg_wr && reg_addr == 8'h20)
         mode_reg <= reg_wdata[7:6];
   sequence s_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   AST_RDATA_IDLE: assert property
      (!reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
   AST_CTRL0_RSVD: assert property
      (s_rd(8'h20) |=> !(reg_rdata & 8'h13)) else $error("reserved bit");
   AST_UNMAPPED: assert property
      (reg_rd && reg_addr > 8'h25 |=> !reg_rdata) else $error("unmapped");
   AST_MODE_OFF: assert property
      ($past(mode_reg) == 2'h0 && $past(mode_reg, 2) == 2'h0 |->
      match_status == 2'h0) else $error("match while off");
   AST_QUIET_DEBUG: assert property
      (debug_active [*2] |-> !swi_request && !debug_request)
      else $error("break in debug");
   AST_DBG_ENABLED: assert property
      (debug_request |-> $past(debug_enabled)) else $error("debug off");
   AST_SWI_MODE: assert property
      (swi_request |-> $past(mode_reg) == 2'h1 && $past(head_execute))
      else $error("bad swi");
   AST_DBG_HEAD: assert property
      (debug_request |-> $past(mode_reg[1]) && $past(head_execute))
      else $error("bad debug entry");
endmodule
bind bkpc_comparator bkpc_comparator_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u
(
   .clk, .rst, .por, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .head_execute, .debug_active, .debug_enabled, .swi_request,
   .debug_request, .match_status
);

// ### bkpc_cpu_model.sv
// CPU core bus model for the breakpoint comparator
`timescale 1ns/1ns
module bkpc_cpu_model
(
   // Clock
   input wire clk,
   // CPU bus
   output logic bus_valid = 1'h0,
   output logic [15:0] bus_addr = 16'h0000,
   output logic [15:0] bus_data = 16'h0000,
   output logic bus_read = 1'h0,
   output logic bus_fetch = 1'h0,
   output logic queue_advance = 1'h0,
   output logic head_execute = 1'h0
);
   // Released lines invert so a stale value never matches
   task cyc(input [15:0] a, d, input r, f);
      @(posedge clk);
      bus_valid <= 1'h1;
      bus_addr <= a;
      bus_data <= d;
      bus_read <= r;
      bus_fetch <= f;
      @(posedge clk);
      bus_valid <= 1'h0;
      bus_fetch <= 1'h0;
      bus_addr <= ~a;
      bus_data <= ~d;
   endtask
   task step(input adv, hd);
      @(posedge clk);
      queue_advance <= adv;
      head_execute <= hd;
      @(posedge clk);
      queue_advance <= 1'h0;
      head_execute <= 1'h0;
   endtask
endmodule

// ### bkpc_defines.vh
// Offsets, field positions and reset values of the breakpoint comparator
`ifndef BKPC_DEFINES_VH
`define BKPC_DEFINES_VH

// Register offsets
`define BKPC_OFS_CTRL0 8'h20
`define BKPC_OFS_CTRL1 8'h21
`define BKPC_OFS_ADDR_HI 8'h22
`define BKPC_OFS_ADDR_LO 8'h23
`define BKPC_OFS_DATA_HI 8'h24
`define BKPC_OFS_DATA_LO 8'h25

// Reset values
`define BKPC_CTRL_RESET 8'h00
`define BKPC_CMP_RESET 8'h00

// Control register 0 fields
`define BKPC_MODE_HI 7
`define BKPC_MODE_LO 6
`define BKPC_PROG_ADDR 5
`define BKPC_SECOND_ALE 3
`define BKPC_FIRST_ALE 2
`define BKPC_CTRL0_MASK 8'hEC

// Control register 1 fields
`define BKPC_DATA_EN 6
`define BKPC_HIGH_MASK 5
`define BKPC_LOW_MASK 4
`define BKPC_SECOND_RWE 3
`define BKPC_SECOND_RW 2
`define BKPC_FIRST_RWE 1
`define BKPC_FIRST_RW 0
`define BKPC_CTRL1_MASK 8'h7F

// Mode encodings
`define BKPC_MODE_OFF 2'b00
`define BKPC_MODE_SWI_DUAL 2'b01
`define BKPC_MODE_BDM_FULL 2'b10
`define BKPC_MODE_BDM_DUAL 2'b11

`endif

// ### tb_bkpc_comparator.sv
// Self-checking bench for the breakpoint comparator
`timescale 1ns/1ns
module tb_bkpc_comparator;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic por = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic debug_active = 1'h0;
   logic debug_enabled = 1'h1;
   logic [7:0] reg_rdata;
   logic [15:0] bus_addr, bus_data;
   logic bus_valid, bus_read, bus_fetch, queue_advance, head_execute;
   logic swi_request, debug_request;
   logic [2:0] queue_tags;
   logic [1:0] match_status;
   int errors = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   bkpc_cpu_model cpu_u (.clk, .bus_valid, .bus_addr, .bus_data, .bus_read,
      .bus_fetch, .queue_advance, .head_execute);
   bkpc_comparator dut_u (.clk, .rst, .por, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .bus_valid, .bus_addr, .bus_data, .bus_read,
      .bus_fetch, .queue_advance, .head_execute, .debug_active,
      .debug_enabled, .swi_request, .debug_request, .queue_tags,
      .match_status);
   task chk(input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task reset(input p);
      rst <= 1'h1;
      por <= p;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      por <= 1'h0;
   endtask
   task wr(input [7:0] a, d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task rd(input [7:0] a, e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask
   task hit(input [15:0] a, d, input r, input [1:0] e);
      cpu_u.cyc(a, d, r, 1'h0);
      #1 chk(match_status, e);
   endtask
   // Requests are one-cycle pulses, so sample every cycle
   task req(input [1:0] e);
      logic [1:0] seen;
      seen = 2'h0;
      repeat (4)
      begin
         #1 seen = seen | {swi_request, debug_request};
         @(posedge clk);
      end
      chk(seen, e);
   endtask
   task t_regs;
      rd(8'h20, 8'h00);
      wr(8'h20, 8'hFF);
      wr(8'h21, 8'hFF);
      rd(8'h20, 8'hEC);
      rd(8'h21, 8'h7F);
      rd(8'h30, 8'h00);
      wr(8'h22, 8'h12);
      reset(1'h0);
      rd(8'h22, 8'h12);
      rd(8'h21, 8'h00);
      reset(1'h1);
      rd(8'h22, 8'h00);
   endtask
   task t_swi;
      wr(8'h22, 8'h12);
      wr(8'h23, 8'h34);
      wr(8'h24, 8'h56);
      wr(8'h25, 8'h78);
      wr(8'h20, 8'h44);
      wr(8'h21, 8'h0F);
      hit(16'h1234, 16'h0000, 1'h0, 2'h1);
      hit(16'h1235, 16'h0000, 1'h1, 2'h0);
      hit(16'h5678, 16'h0000, 1'h1, 2'h0);
      wr(8'h21, 8'h4F);
      hit(16'h56FF, 16'h0000, 1'h0, 2'h2);
      wr(8'h20, 8'h48);
      hit(16'h12FF, 16'h0000, 1'h1, 2'h1);
      hit(16'h56FF, 16'h0000, 1'h1, 2'h0);
      cpu_u.cyc(16'h1200, 16'h0000, 1'h1, 1'h1);
      #1 chk(queue_tags, 3'h1);
      cpu_u.step(1'h1, 1'h0);
      cpu_u.step(1'h1, 1'h0);
      #1 chk(queue_tags, 3'h4);
      cpu_u.step(1'h0, 1'h1);
      req(2'h2);
   endtask
   task t_full;
      wr(8'h20, 8'h84);
      wr(8'h21, 8'h40);
      hit(16'h1234, 16'h5678, 1'h1, 2'h1);
      hit(16'h1234, 16'h56FF, 1'h1, 2'h0);
      wr(8'h21, 8'h50);
      hit(16'h1234, 16'h56FF, 1'h1, 2'h1);
      wr(8'h21, 8'h6B);
      hit(16'h1234, 16'hFF78, 1'h0, 2'h0);
      hit(16'h1234, 16'hFF78, 1'h1, 2'h1);
      cpu_u.step(1'h0, 1'h1);
      req(2'h1);
      debug_active <= 1'h1;
      hit(16'h1234, 16'hFF78, 1'h1, 2'h0);
      cpu_u.step(1'h0, 1'h1);
      req(2'h0);
      debug_active <= 1'h0;
      debug_enabled <= 1'h0;
      hit(16'h1234, 16'hFF78, 1'h1, 2'h1);
      cpu_u.step(1'h0, 1'h1);
      req(2'h0);
   endtask
   task t_dual;
      debug_enabled <= 1'h1;
      wr(8'h20, 8'hCC);
      wr(8'h21, 8'h4E);
      hit(16'h1234, 16'h0000, 1'h0, 2'h1);
      hit(16'h5678, 16'h0000, 1'h1, 2'h2);
      hit(16'h5678, 16'h0000, 1'h0, 2'h0);
      cpu_u.step(1'h0, 1'h1);
      req(2'h1);
      wr(8'h20, 8'hEC);
      hit(16'h1234, 16'h0000, 1'h1, 2'h1);
      hit(16'h5678, 16'h0000, 1'h0, 2'h2);
      wr(8'h20, 8'h00);
      hit(16'h1234, 16'h0000, 1'h1, 2'h0);
   endtask
   initial
   begin
      reset(1'h1);
      t_regs;
      t_swi;
      t_full;
      t_dual;
      conclude;
   end
endmodule
